// [inc/usdp_defines.svh]
// address map, field positions and reset values of the shadow data port
`ifndef USDP_DEFINES_SVH
`define USDP_DEFINES_SVH

// sixteen aliased shadow words, the 13th of them at 0x50001160
`define USDP_SHADOW_BASE      32'h5000_1130
`define USDP_SHADOW_LAST      32'h5000_116C
`define USDP_SHADOW_12        32'h5000_1160
`define USDP_SHADOW_13        32'h5000_1164
`define USDP_SHADOW_RESET     32'h0000_0000

// side registers
`define USDP_CTRL_ADDR        32'h5000_1180
`define USDP_LSTAT_ADDR       32'h5000_1184
`define USDP_IRQ_STAT_ADDR    32'h5000_1188
`define USDP_IRQ_MASK_ADDR    32'h5000_118C

// fifo_control fields
`define USDP_CTRL_FIFO_EN     0
`define USDP_CTRL_IR_MODE     1
`define USDP_CTRL_RESET       2'h0

// line_status fields
`define USDP_LS_RX_READY      0
`define USDP_LS_OVERRUN       1
`define USDP_LS_TX_EMPTY      5
`define USDP_LS_RX_CNT_LSB    8
`define USDP_LS_TX_CNT_LSB    16

// interrupt status / mask fields
`define USDP_IRQ_RX_CHAR      0
`define USDP_IRQ_OVERRUN      1
`define USDP_IRQ_TX_DROP      2
`define USDP_IRQ_TX_EMPTY     3
`define USDP_IRQ_W            4
`define USDP_IRQ_RESET        4'h0

// default fifo depth in characters
`define USDP_FIFO_DEPTH       16

`endif

// [inc/usdp_pkg.sv]
// types shared by the shadow data port
package usdp_pkg;

    typedef logic [7:0] usdp_byte_type;

    // register targets of an address phase
    typedef enum logic [2:0]
    {
        USDP_T_NONE,
        USDP_T_SHADOW,
        USDP_T_CTRL,
        USDP_T_LSTAT,
        USDP_T_IRQ_STAT,
        USDP_T_IRQ_MASK
    } usdp_target_type;

endpackage

// [rtl/usdp_top.sv]
// shadow receive/transmit data port with ahb-lite registers and fifos
`timescale 1ns/1ns
`default_nettype none
`include "usdp_defines.svh"

module usdp_top
#(
    parameter int DEPTH = `USDP_FIFO_DEPTH
)
(
    // clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // received characters from the serial and infrared framers
    input  wire logic        uart_rx_valid,
    input  wire logic [7:0]  uart_rx_byte,
    input  wire logic        ir_rx_valid,
    input  wire logic [7:0]  ir_rx_byte,
    // characters to the serial and infrared framers
    output logic             uart_tx_valid,
    output logic             ir_tx_valid,
    output logic      [7:0]  tx_byte,
    input  wire logic        tx_take,
    // interrupt
    output logic             irq
);

    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

    // address decode for one address phase
    function automatic usdp_pkg::usdp_target_type decode
    (
        input logic [31:0] a
    );
        usdp_pkg::usdp_target_type t;
        t = usdp_pkg::USDP_T_NONE;
        if (a[1:0] != 2'h0)
            t = usdp_pkg::USDP_T_NONE;
        else if (a >= `USDP_SHADOW_BASE && a <= `USDP_SHADOW_LAST)
            t = usdp_pkg::USDP_T_SHADOW;
        else if (a == `USDP_CTRL_ADDR)
            t = usdp_pkg::USDP_T_CTRL;
        else if (a == `USDP_LSTAT_ADDR)
            t = usdp_pkg::USDP_T_LSTAT;
        else if (a == `USDP_IRQ_STAT_ADDR)
            t = usdp_pkg::USDP_T_IRQ_STAT;
        else if (a == `USDP_IRQ_MASK_ADDR)
            t = usdp_pkg::USDP_T_IRQ_MASK;
        return t;
    endfunction

    // storage
    usdp_pkg::usdp_byte_type rx_mem [DEPTH];
    usdp_pkg::usdp_byte_type tx_mem [DEPTH];
    logic [PW-1:0]           rx_rp_r;
    logic [PW-1:0]           rx_wp_r;
    logic [CW-1:0]           rx_cnt_r;
    logic [PW-1:0]           tx_rp_r;
    logic [PW-1:0]           tx_wp_r;
    logic [CW-1:0]           tx_cnt_r;
    logic [1:0]              ctrl_r;
    logic                    ovr_r;
    logic [`USDP_IRQ_W-1:0]  ist_r;
    logic [`USDP_IRQ_W-1:0]  imask_r;
    logic                    wr_pend_r;
    usdp_pkg::usdp_target_type wr_tgt_r;
    logic [31:0]             hrdata_r;

    // bus address phase
    wire logic               acc_ok;
    wire usdp_pkg::usdp_target_type tgt;
    wire logic               rd_acc;
    wire logic               wr_data;
    assign acc_ok   = hsel && hready && htrans[1];
    assign tgt      = decode(haddr);
    assign rd_acc   = acc_ok && !hwrite;
    assign wr_data  = wr_pend_r;

    // zero wait state slave, always okay
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_r;

    // mode selects
    wire logic fifo_en;
    wire logic ir_mode;
    assign fifo_en = ctrl_r[`USDP_CTRL_FIFO_EN];
    assign ir_mode = ctrl_r[`USDP_CTRL_IR_MODE];

    // control write flushes both paths so a mode change starts clean
    wire logic ctrl_wr;
    assign ctrl_wr = wr_data && wr_tgt_r == usdp_pkg::USDP_T_CTRL;

    // receive path: the selected source feeds the buffer
    wire logic          rx_in_valid;
    wire logic [7:0]    rx_in_byte;
    wire logic          rx_hold_full;
    wire logic          rx_pop;
    wire logic          rx_ovr;
    wire logic          rx_ovw;
    wire logic          rx_push;
    wire logic [7:0]    rx_head;
    assign rx_in_valid  = ir_mode ? ir_rx_valid : uart_rx_valid;
    assign rx_in_byte   = ir_mode ? ir_rx_byte : uart_rx_byte;
    // single holding byte without fifo, full depth with it
    assign rx_hold_full = fifo_en ? (rx_cnt_r == FULL_CNT)
                                  : (rx_cnt_r != '0);
    // every shadow alias reads the one head entry
    assign rx_pop  = rd_acc && tgt == usdp_pkg::USDP_T_SHADOW
                     && rx_cnt_r != '0;
    assign rx_ovr  = rx_in_valid && rx_hold_full && !rx_pop;
    assign rx_ovw  = rx_ovr && !fifo_en;
    assign rx_push = rx_in_valid && (!rx_hold_full || rx_pop);
    assign rx_head = rx_mem[rx_rp_r];

    // transmit path
    wire logic          tx_wr;
    wire logic          tx_hold_full;
    wire logic          tx_pop;
    wire logic          tx_drop;
    wire logic          tx_ovw;
    wire logic          tx_push;
    wire logic          tx_empty_evt;
    wire logic          tx_holding_empty;
    // any shadow alias written feeds the transmitter
    assign tx_wr        = wr_data && wr_tgt_r == usdp_pkg::USDP_T_SHADOW;
    assign tx_hold_full = fifo_en ? (tx_cnt_r == FULL_CNT)
                                  : (tx_cnt_r != '0);
    assign tx_pop       = tx_take && tx_cnt_r != '0;
    assign tx_drop = tx_wr && fifo_en && tx_hold_full && !tx_pop;
    assign tx_ovw  = tx_wr && !fifo_en && tx_hold_full && !tx_pop;
    assign tx_push      = tx_wr && (!tx_hold_full || tx_pop);
    assign tx_empty_evt = tx_pop && tx_cnt_r == CW'(1) && !tx_push;
    // holding empty flag follows the occupancy, so one write clears it
    assign tx_holding_empty         = tx_cnt_r == '0;

    // serializer side; only one framer sees a character
    assign uart_tx_valid = !tx_holding_empty && !ir_mode;
    assign ir_tx_valid   = !tx_holding_empty && ir_mode;
    assign tx_byte       = tx_mem[tx_rp_r];

    // read mux; the byte sits in the low lane, the rest reads zero
    logic [31:0] rd_val;
    always_comb
    begin
        rd_val = 32'h0000_0000;
        unique case (tgt)
            usdp_pkg::USDP_T_SHADOW:
                rd_val = {24'h00_0000, rx_head};
            usdp_pkg::USDP_T_CTRL:
                rd_val = {30'h0000_0000, ctrl_r};
            usdp_pkg::USDP_T_LSTAT:
            begin
                rd_val[`USDP_LS_RX_READY] = rx_cnt_r != '0;
                rd_val[`USDP_LS_OVERRUN]  = ovr_r;
                rd_val[`USDP_LS_TX_EMPTY] = tx_holding_empty;
                rd_val[`USDP_LS_RX_CNT_LSB +: 8] = 8'(rx_cnt_r);
                rd_val[`USDP_LS_TX_CNT_LSB +: 8] = 8'(tx_cnt_r);
            end
            usdp_pkg::USDP_T_IRQ_STAT:
                rd_val = {28'h000_0000, ist_r};
            usdp_pkg::USDP_T_IRQ_MASK:
                rd_val = {28'h000_0000, imask_r};
            usdp_pkg::USDP_T_NONE:
                rd_val = 32'h0000_0000;
        endcase
    end

    // bus pipeline: read data captured at the address phase
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_r <= 1'b0;
            wr_tgt_r  <= usdp_pkg::USDP_T_NONE;
            hrdata_r  <= `USDP_SHADOW_RESET;
        end
        else
        begin
            wr_pend_r <= acc_ok && hwrite;
            wr_tgt_r  <= tgt;
            if (rd_acc)
                hrdata_r <= rd_val;
        end
    end

    // control register; only the low bits are kept
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            ctrl_r <= `USDP_CTRL_RESET;
        else if (ctrl_wr)
            ctrl_r <= hwdata[1:0];
    end

    // receive occupancy and pointers
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            rx_rp_r  <= '0;
            rx_wp_r  <= '0;
            rx_cnt_r <= '0;
        end
        else if (ctrl_wr)
        begin
            rx_rp_r  <= '0;
            rx_wp_r  <= '0;
            rx_cnt_r <= '0;
        end
        else
        begin
            if (rx_push)
                rx_wp_r <= PW'(rx_wp_r + PW'(1));
            if (rx_pop)
                rx_rp_r <= PW'(rx_rp_r + PW'(1));
            rx_cnt_r <= CW'(rx_cnt_r + CW'(rx_push) - CW'(rx_pop));
        end
    end

    // receive storage; a full fifo keeps its contents
    always_ff @(posedge hclk)
    begin
        if (rx_push)
            rx_mem[rx_wp_r] <= rx_in_byte;
        else if (rx_ovw)
            rx_mem[rx_rp_r] <= rx_in_byte;
    end

    // transmit occupancy and pointers
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            tx_rp_r  <= '0;
            tx_wp_r  <= '0;
            tx_cnt_r <= '0;
        end
        else if (ctrl_wr)
        begin
            tx_rp_r  <= '0;
            tx_wp_r  <= '0;
            tx_cnt_r <= '0;
        end
        else
        begin
            if (tx_push)
                tx_wp_r <= PW'(tx_wp_r + PW'(1));
            if (tx_pop)
                tx_rp_r <= PW'(tx_rp_r + PW'(1));
            tx_cnt_r <= CW'(tx_cnt_r + CW'(tx_push) - CW'(tx_pop));
        end
    end

    // transmit storage; upper write bits are never stored
    always_ff @(posedge hclk)
    begin
        if (tx_push)
            tx_mem[tx_wp_r] <= hwdata[7:0];
        else if (tx_ovw)
            tx_mem[tx_rp_r] <= hwdata[7:0];
    end

    // interrupt events; a set in the clearing cycle wins
    wire logic [`USDP_IRQ_W-1:0] evt;
    wire logic [`USDP_IRQ_W-1:0] ist_clr;
    wire logic [`USDP_IRQ_W-1:0] ist_nxt;
    assign evt[`USDP_IRQ_RX_CHAR]  = rx_push;
    assign evt[`USDP_IRQ_OVERRUN]  = rx_ovr;
    assign evt[`USDP_IRQ_TX_DROP]  = tx_drop;
    assign evt[`USDP_IRQ_TX_EMPTY] = tx_empty_evt;
    assign ist_clr = (wr_data && wr_tgt_r == usdp_pkg::USDP_T_IRQ_STAT)
                     ? hwdata[`USDP_IRQ_W-1:0] : '0;
    assign ist_nxt = (ist_r & ~ist_clr) | evt;
    assign irq     = |(ist_r & imask_r);

    // sticky status, mask, and line overrun flag cleared by status read
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ist_r   <= `USDP_IRQ_RESET;
            imask_r <= `USDP_IRQ_RESET;
            ovr_r   <= 1'b0;
        end
        else
        begin
            ist_r <= ist_nxt;
            if (wr_data && wr_tgt_r == usdp_pkg::USDP_T_IRQ_MASK)
                imask_r <= hwdata[`USDP_IRQ_W-1:0];
            if (rx_ovr)
                ovr_r <= 1'b1;
            else if (rd_acc && tgt == usdp_pkg::USDP_T_LSTAT)
                ovr_r <= 1'b0;
        end
    end

    // checks on the data path
    a_alias_read_head: assert property (
        @(posedge hclk) disable iff (!hresetn)
        rx_pop |=> hrdata[7:0] == $past(rx_head))
        else $error("shadow read did not return the head byte");

    a_ir_source_sel: assert property (
        @(posedge hclk) disable iff (!hresetn)
        ir_mode && uart_rx_valid && !ir_rx_valid && rx_cnt_r == '0
        && !ctrl_wr |=> rx_cnt_r == '0)
        else $error("serial input accepted in infrared mode");

    a_rx_overwrite: assert property (
        @(posedge hclk) disable iff (!hresetn)
        !fifo_en && rx_in_valid && rx_cnt_r != '0 && !rx_pop && !ctrl_wr
        |=> rx_cnt_r == CW'(1) && rx_head == $past(rx_in_byte)
            && ist_r[`USDP_IRQ_OVERRUN])
        else $error("unread byte not overwritten with overrun");

    a_rx_pop_count: assert property (
        @(posedge hclk) disable iff (!hresetn)
        rx_pop && !rx_push && !ctrl_wr
        |=> rx_cnt_r == CW'($past(rx_cnt_r) - CW'(1)))
        else $error("shadow read did not pop the receive fifo");

    a_rx_full_keep: assert property (
        @(posedge hclk) disable iff (!hresetn)
        fifo_en && rx_cnt_r == FULL_CNT && rx_in_valid && !rx_pop
        && !ctrl_wr
        |=> rx_cnt_r == FULL_CNT && $stable(rx_wp_r) && ovr_r)
        else $error("full receive fifo changed on arrival");

    a_tx_mode_out: assert property (
        @(posedge hclk) disable iff (!hresetn)
        tx_wr && tx_holding_empty && !ctrl_wr
        |=> (ir_mode ? ir_tx_valid : uart_tx_valid)
            && !(uart_tx_valid && ir_tx_valid))
        else $error("written byte not offered to the active framer");

    a_tx_holding_empty_clear: assert property (
        @(posedge hclk) disable iff (!hresetn)
        !fifo_en && tx_holding_empty && tx_wr && !ctrl_wr
        |=> !tx_holding_empty && tx_byte == $past(hwdata[7:0]))
        else $error("single write did not clear holding empty");

    a_tx_replace: assert property (
        @(posedge hclk) disable iff (!hresetn)
        !fifo_en && !tx_holding_empty && tx_wr && !tx_take && !ctrl_wr
        |=> tx_cnt_r == CW'(1) && tx_byte == $past(hwdata[7:0]))
        else $error("pending transmit byte not replaced");

    a_tx_fill_depth: assert property (
        @(posedge hclk) disable iff (!hresetn)
        fifo_en && tx_wr && tx_cnt_r < FULL_CNT && !tx_take && !ctrl_wr
        |=> tx_cnt_r == CW'($past(tx_cnt_r) + CW'(1)))
        else $error("transmit fifo refused a write below depth");

    a_tx_full_drop: assert property (
        @(posedge hclk) disable iff (!hresetn)
        tx_drop && !ctrl_wr
        |=> tx_cnt_r == FULL_CNT && $stable(tx_wp_r)
            && ist_r[`USDP_IRQ_TX_DROP])
        else $error("write to full transmit fifo not discarded");

    a_upper_zero: assert property (
        @(posedge hclk) disable iff (!hresetn)
        rd_acc && tgt == usdp_pkg::USDP_T_SHADOW |=> hrdata[31:8] == '0)
        else $error("shadow read upper bits not zero");

endmodule
`default_nettype wire

// [verif/uart_shadow_data_port_bench.sv]
// self-checking bench of the shadow data port
`timescale 1ns/1ns
`default_nettype none
`include "usdp_defines.svh"
module uart_shadow_data_port_bench;
    localparam int D = `USDP_FIFO_DEPTH;
    localparam logic [31:0] LS = `USDP_LSTAT_ADDR;
    localparam logic [31:0] SH = `USDP_SHADOW_BASE;
    localparam logic [31:0] ALL = 32'hFFFF_FFFF;
    localparam logic [31:0] RDY = 32'h1 << `USDP_LS_RX_READY;
    localparam logic [31:0] OVR = 32'h1 << `USDP_LS_OVERRUN;
    localparam logic [31:0] TXE = 32'h1 << `USDP_LS_TX_EMPTY;
    localparam logic [31:0] RXC = 32'hFF << `USDP_LS_RX_CNT_LSB;
    localparam logic [31:0] TXC = 32'hFF << `USDP_LS_TX_CNT_LSB;
    localparam logic [31:0] DROP = 32'h1 << `USDP_IRQ_TX_DROP;
    localparam logic [31:0] FIFO = 32'h1 << `USDP_CTRL_FIFO_EN;
    localparam logic [31:0] IRM = 32'h1 << `USDP_CTRL_IR_MODE;

    typedef struct {
        logic       fifo;
        logic       ir;
        logic [3:0] slot;
        logic [7:0] b;
    } usdp_row_type;

    // mode, alias slot and byte of each ordinary case
    usdp_row_type rows [4] = '{
        '{1'b0, 1'b0, 4'h0, 8'hA5},
        '{1'b0, 1'b1, 4'h5, 8'h3C},
        '{1'b1, 1'b0, 4'hC, 8'h81},
        '{1'b1, 1'b1, 4'hF, 8'h7E}};

    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        hold;
    logic        uart_rx_valid;
    logic [7:0]  uart_rx_byte;
    logic        ir_rx_valid;
    logic [7:0]  ir_rx_byte;
    logic        uart_tx_valid;
    logic        ir_tx_valid;
    logic [7:0]  tx_byte;
    logic        tx_take;
    logic        irq;
    logic [31:0] a;
    int          num_errors;
    int          check_count;

    usdp_top #(.DEPTH(D)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp),
        .uart_rx_valid(uart_rx_valid), .uart_rx_byte(uart_rx_byte),
        .ir_rx_valid(ir_rx_valid), .ir_rx_byte(ir_rx_byte),
        .uart_tx_valid(uart_tx_valid), .ir_tx_valid(ir_tx_valid),
        .tx_byte(tx_byte), .tx_take(tx_take), .irq(irq));

    usdp_framer_model far (.hclk(hclk), .hresetn(hresetn),
        .uart_rx_valid(uart_rx_valid), .uart_rx_byte(uart_rx_byte),
        .ir_rx_valid(ir_rx_valid), .ir_rx_byte(ir_rx_byte),
        .uart_tx_valid(uart_tx_valid), .ir_tx_valid(ir_tx_valid),
        .tx_byte(tx_byte), .tx_take(tx_take), .hold(hold));

    // 100 MHz clock
    always #5 hclk = ~hclk;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks=%0d errors=%0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // a wait that runs out counts as a mismatch and ends the run
    task automatic timed_out();
        num_errors++;
        $display("[ERR] t=%0t seen=%h exp=%h", $time, 32'h0, 32'h1);
        tally_and_finish();
    endtask

    // next rising edge with hready high, bounded
    task automatic wait_ready();
        int n;
        n = 0;
        @(posedge hclk);
        while (hready_seen() !== 1'b1)
        begin
            n++;
            if (n > 50)
                timed_out();
            @(posedge hclk);
        end
    endtask

    function automatic logic hready_seen();
        return hreadyout;
    endfunction

    // one single ahb-lite transfer, address phase then data phase
    task automatic ahb_xfer(input logic [31:0] ad, input logic w,
                            input logic [31:0] wd, output logic [31:0] rd);
        hsel   <= 1'b1;
        haddr  <= ad;
        hwrite <= w;
        htrans <= 2'h2;
        wait_ready();
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
    endtask

    task automatic wr(input logic [31:0] ad, input logic [31:0] d);
        logic [31:0] unused;
        ahb_xfer(ad, 1'b1, d, unused);
    endtask

    // read, keep the masked bits, compare
    task automatic rd_chk(input logic [31:0] ad, input logic [31:0] m,
                          input logic [31:0] exp);
        logic [31:0] rd;
        ahb_xfer(ad, 1'b0, 32'h0, rd);
        check(rd & m, exp);
    endtask

    task automatic wait_got(input int n);
        int k;
        k = 0;
        while (far.got.size() < n)
        begin
            k++;
            if (k > 300)
                timed_out();
            @(posedge hclk);
        end
    endtask

    // reset for four cycles, then check the idle state
    task automatic reset_checks();
        hresetn <= 1'b0;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        check({27'h0, hreadyout, hresp, irq, uart_tx_valid, ir_tx_valid},
              32'h10);
        check(hrdata, 32'h0);
        rd_chk(LS, ALL, TXE);
        rd_chk(`USDP_CTRL_ADDR, ALL, 32'h0);
        rd_chk(`USDP_IRQ_MASK_ADDR, ALL, 32'h0);
        $display("test reset done");
    endtask

    initial
    begin
        hclk = 1'b0;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        hold = 1'b0;
        num_errors = 0;
        check_count = 0;
        reset_checks();
        // ordinary cases: receive and transmit in every mode
        foreach (rows[i])
        begin
            wr(`USDP_CTRL_ADDR,
               (rows[i].fifo ? FIFO : 0) | (rows[i].ir ? IRM : 0));
            a = SH + {26'h0, rows[i].slot, 2'h0};
            far.send_rx(rows[i].ir, rows[i].b);
            rd_chk(LS, RDY | TXE, RDY | TXE);
            rd_chk(a, ALL, {24'h0, rows[i].b});
            rd_chk(LS, RDY, 32'h0);
            wr(a, 32'hFFFF_FF00 | {24'h0, rows[i].b});
            wait_got(1);
            check({23'h0, far.got.pop_front()},
                  {23'h0, rows[i].ir, rows[i].b});
        end
        $display("test rows done");
        // no fifo: second byte overwrites the unread first one
        wr(`USDP_CTRL_ADDR, 32'h0);
        far.send_rx(1'b0, 8'h11);
        far.send_rx(1'b0, 8'h22);
        rd_chk(LS, OVR | RDY, OVR | RDY);
        rd_chk(`USDP_SHADOW_12, ALL, 32'h22);
        $display("test rx overwrite done");
        // fifo on: fill, overflow by one, drain in order over all aliases
        wr(`USDP_CTRL_ADDR, FIFO);
        for (int i = 0; i < D; i++)
            far.send_rx(1'b0, 8'(8'h40 + i));
        rd_chk(LS, OVR, 32'h0);
        far.send_rx(1'b0, 8'hEE);
        rd_chk(LS, OVR | RXC, OVR | (32'(D) << `USDP_LS_RX_CNT_LSB));
        for (int i = 0; i < D; i++)
            rd_chk(SH + 32'(4 * (i % 16)), ALL, 32'(8'h40 + i));
        rd_chk(LS, RDY, 32'h0);
        $display("test rx fifo done");
        // no fifo: further writes replace the pending byte
        hold <= 1'b1;
        wr(`USDP_CTRL_ADDR, 32'h0);
        rd_chk(LS, TXE, TXE);
        wr(`USDP_SHADOW_13, 32'h55);
        rd_chk(LS, TXE, 32'h0);
        wr(`USDP_SHADOW_13, 32'h66);
        wr(SH, 32'h77);
        hold <= 1'b0;
        wait_got(1);
        repeat (20) @(posedge hclk);
        check(32'(far.got.size()), 32'h1);
        check({23'h0, far.got.pop_front()}, 32'h77);
        rd_chk(LS, TXE, TXE);
        $display("test tx replace done");
        // fifo on: fill to depth, one dropped write, masked interrupt
        hold <= 1'b1;
        wr(`USDP_CTRL_ADDR, FIFO);
        wr(`USDP_IRQ_STAT_ADDR, 32'hF);
        for (int i = 0; i < D; i++)
            wr(SH + 32'(4 * (i % 16)), 32'(8'h80 + i));
        rd_chk(LS, TXC, 32'(D) << `USDP_LS_TX_CNT_LSB);
        wr(`USDP_SHADOW_12, 32'hEE);
        rd_chk(LS, TXC, 32'(D) << `USDP_LS_TX_CNT_LSB);
        rd_chk(`USDP_IRQ_STAT_ADDR, DROP, DROP);
        check({31'h0, irq}, 32'h0);
        wr(`USDP_IRQ_MASK_ADDR, DROP);
        repeat (2) @(posedge hclk);
        check({31'h0, irq}, 32'h1);
        wr(`USDP_IRQ_STAT_ADDR, DROP);
        repeat (2) @(posedge hclk);
        check({31'h0, irq}, 32'h0);
        rd_chk(`USDP_IRQ_MASK_ADDR, ALL, DROP);
        wr(32'h5000_1190, ALL);
        rd_chk(32'h5000_1190, ALL, 32'h0);
        hold <= 1'b0;
        wait_got(D);
        for (int i = 0; i < D; i++)
            check({23'h0, far.got.pop_front()},
                  32'(8'h80 + i));
        // the last take emptied the buffer and raised the empty event
        rd_chk(`USDP_IRQ_STAT_ADDR, 32'h8, 32'h8);
        $display("test tx fifo done");
        // reset in mid-run with a byte pending
        hold <= 1'b1;
        wr(`USDP_SHADOW_12, 32'h5A);
        reset_checks();
        hold <= 1'b0;
        tally_and_finish();
    end
endmodule
`default_nettype wire

// [verif/usdp_framer_model.sv]
// far-side model: serial and infrared framers around the data port
`timescale 1ns/1ns
`default_nettype none
module usdp_framer_model
(
    // clock and reset
    input  wire logic       hclk,
    input  wire logic       hresetn,
    // received characters toward the port
    output logic            uart_rx_valid,
    output logic      [7:0] uart_rx_byte,
    output logic            ir_rx_valid,
    output logic      [7:0] ir_rx_byte,
    // characters from the port
    input  wire logic       uart_tx_valid,
    input  wire logic       ir_tx_valid,
    input  wire logic [7:0] tx_byte,
    output logic            tx_take,
    // stalls the transmit side while high
    input  wire logic       hold
);
    logic [8:0] got [$];

    // idle lines at time zero
    initial
    begin
        uart_rx_valid = 1'b0;
        ir_rx_valid   = 1'b0;
        uart_rx_byte  = 8'h00;
        ir_rx_byte    = 8'hFF;
    end

    // one character on the selected path, a decoy on the other one,
    // so a port listening on the wrong path reads the wrong byte
    task automatic send_rx(input logic ir, input logic [7:0] b);
        @(posedge hclk);
        uart_rx_valid <= 1'b1;
        ir_rx_valid   <= 1'b1;
        uart_rx_byte  <= ir ? ~b : b;
        ir_rx_byte    <= ir ? b : ~b;
        @(posedge hclk);
        uart_rx_valid <= 1'b0;
        ir_rx_valid   <= 1'b0;
        // released data lines must not keep showing the last byte
        uart_rx_byte  <= ~uart_rx_byte;
        ir_rx_byte    <= ~ir_rx_byte;
    endtask

    // take every other cycle at most; the byte is logged at the edge
    // where the port samples the take pulse, while it still stands
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            tx_take <= 1'b0;
        else if (tx_take)
        begin
            got.push_back({ir_tx_valid, tx_byte});
            tx_take <= 1'b0;
        end
        else if ((uart_tx_valid || ir_tx_valid) && !hold)
            tx_take <= 1'b1;
    end
endmodule
`default_nettype wire
